// >>> rtl/special_input_pkg.sv
// Purpose: Shared constants for the special input counter block
// Assumes: 100 MHz core clock, byte addressed register port
// Notes:   Offsets are word aligned; all timing counts derive from ns figures
package special_input_pkg;

  // Register offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] PM_EN_OFS     = 8'h04;
  localparam logic [7:0] EDGE_EN_OFS   = 8'h08;
  localparam logic [7:0] EDGE_POL_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS    = 8'h10;
  localparam logic [7:0] TARGET0_OFS   = 8'h14;
  localparam logic [7:0] TARGET1_OFS   = 8'h18;
  localparam logic [7:0] COUNT0_OFS    = 8'h1c;
  localparam logic [7:0] COUNT1_OFS    = 8'h20;
  localparam logic [7:0] WIDTH0_OFS    = 8'h24;
  localparam logic [7:0] WIDTH1_OFS    = 8'h28;
  localparam logic [7:0] FREQ0_OFS     = 8'h2c;
  localparam logic [7:0] FREQ1_OFS     = 8'h30;
  localparam logic [7:0] PINS_OFS      = 8'h34;

  // Field positions in the control register
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_CNT_EN_LSB = 2;
  // Field positions in the status register
  localparam int STAT_MATCH_LSB  = 0;
  localparam int STAT_EDGE_LSB   = 2;

  // Reset values
  localparam logic [1:0] DECODE_MODE_RST = 2'h0;
  localparam logic [1:0] CNT_EN_RST      = 2'h0;
  localparam logic [1:0] PM_EN_RST       = 2'h0;
  localparam logic [4:0] EDGE_EN_RST     = 5'h00;
  localparam logic [4:0] EDGE_POL_RST    = 5'h1f;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MICROSEC_NS   = 1000;
  localparam int US_CYCLES     = MICROSEC_NS / CLK_PERIOD_NS;
  localparam int FREQ_GATE_MS  = 1000;
  localparam int FREQ_GATE_CYCLES = (FREQ_GATE_MS * 1000) / CLK_PERIOD_NS * 1000;

  // Quadrature step decode result
  typedef enum logic [1:0]
  {
    STEP_NONE = 2'b00,
    STEP_UP   = 2'b10,
    STEP_DOWN = 2'b11
  } quad_step_t;

endpackage : special_input_pkg

// >>> rtl/special_input_counters.sv
// Purpose: Two quadrature counters, five edge event inputs, two pulse meters
// Assumes: Pins 3..7 arrive asynchronously; registers on a plain strobe port
// Notes:   Read data appear one cycle after the read strobe; no wait states
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1 - Two independent up/down counters, fed by inputs 3/4 and 5/6.
// R2 - Channel one counts up once per pulse when input 3 leads input 4.
// R3 - Channel one counts down once per pulse when input 3 lags input 4.
// R4 - Simple mode: input 4 off, pulses on input 3 count up.
// R5 - Simple mode: input 3 off, pulses on input 4 count down.
// R6 - Channel two decodes inputs 5 and 6 exactly like channel one.
// R7 - Each counter has a reloadable target; reaching it requests the custom handler.
// R8 - Encoder pulse rate stays below 10 kHz or 4 kHz per variant.
// R9 - Enhanced mode checks both phases and suppresses jitter counts at edges.
// R10 - Two-bit mode: 0 simple, 1 enhanced ch1, 2 enhanced ch2, 3 both.
// R11 - Inputs 3 to 7 are individually enabled as edge event inputs.
// R12 - Each event input triggers on rising or falling edge, selectable.
// R13 - Selected edge immediately requests its handler; level need not persist.
// R14 - Inputs 3 and 4 measure pulse width in us and frequency in Hz.
// R15 - Signals on pulse measurement inputs stay below 10,000 Hz.
// R16 - Pin never both counter and pulse meter; last configuration wins.
// R17 - Every special input is synchronised before edge or quadrature logic.
module special_input_counters #(
  parameter int CNT_W       = 32,
  parameter int MEAS_W      = 32,
  parameter int GATE_CYCLES = special_input_pkg::FREQ_GATE_CYCLES
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [4:0]        pin_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rd_data_o,
  output logic      [1:0]        match_req_o,
  output logic      [4:0]        edge_req_o
);

  // Quadrature step from previous and present {A,B}
  function automatic special_input_pkg::quad_step_t quad_step(input logic [1:0] prev,
                                                             input logic [1:0] cur);
    case ({prev, cur})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = special_input_pkg::STEP_UP;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = special_input_pkg::STEP_DOWN;
      default:                            quad_step = special_input_pkg::STEP_NONE;
    endcase
  endfunction : quad_step

  // Input synchroniser stages and filtered levels
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] sync3_reg;
  logic [4:0] filt_reg;
  logic [4:0] filt_prev_reg;
  logic [4:0] filt_next;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [4:0] edge_hit;

  // Configuration and status
  logic [1:0] mode_reg;
  logic [1:0] cnt_en_reg;
  logic [1:0] cnt_en_next;
  logic [1:0] pm_en_reg;
  logic [1:0] pm_en_next;
  logic [4:0] edge_en_reg;
  logic [4:0] edge_pol_reg;
  logic [1:0] match_sts_reg;
  logic [4:0] edge_sts_reg;
  logic [1:0] match_req_reg;
  logic [4:0] edge_req_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_mux;

  // Per channel results
  logic [CNT_W-1:0]  count_reg  [2];
  logic [CNT_W-1:0]  target_reg [2];
  logic [MEAS_W-1:0] width_reg  [2];
  logic [MEAS_W-1:0] freq_reg   [2];
  logic [1:0]        match_hit;

  // Bus write decode
  wire wr_ctrl   = wr_i && (addr_i == special_input_pkg::CTRL_OFS);
  wire wr_pm     = wr_i && (addr_i == special_input_pkg::PM_EN_OFS);
  wire wr_een    = wr_i && (addr_i == special_input_pkg::EDGE_EN_OFS);
  wire wr_epol   = wr_i && (addr_i == special_input_pkg::EDGE_POL_OFS);
  wire wr_status = wr_i && (addr_i == special_input_pkg::STATUS_OFS);
  wire [1:0] wr_target = {wr_i && (addr_i == special_input_pkg::TARGET1_OFS),
                          wr_i && (addr_i == special_input_pkg::TARGET0_OFS)};
  wire [1:0] wr_count  = {wr_i && (addr_i == special_input_pkg::COUNT1_OFS),
                          wr_i && (addr_i == special_input_pkg::COUNT0_OFS)};

  // A level change counts only once stages two and three agree
  assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg)); // [R17]
  assign rise      = filt_reg & ~filt_prev_reg;
  assign fall      = ~filt_reg & filt_prev_reg;
  // Selected edge on an enabled event input, shared by request and status
  assign edge_hit  = edge_en_reg & ((rise & edge_pol_reg) | (fall & ~edge_pol_reg)); // [R12]

  // Three-stage pin synchroniser
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg     <= 5'h00;
      sync2_reg     <= 5'h00;
      sync3_reg     <= 5'h00;
      filt_reg      <= 5'h00;
      filt_prev_reg <= 5'h00;
    end
    else
    begin
      sync1_reg     <= pin_i;
      sync2_reg     <= sync1_reg; // [R17]
      sync3_reg     <= sync2_reg;
      filt_reg      <= filt_next;
      filt_prev_reg <= filt_reg;
    end
  end

  // Whichever function was configured last owns pins 3 and 4
  assign cnt_en_next = wr_ctrl ? wr_data_i[special_input_pkg::CTRL_CNT_EN_LSB +: 2]
                               : {cnt_en_reg[1], cnt_en_reg[0] & ~(wr_pm & (|wr_data_i[1:0]))}; // [R16]
  assign pm_en_next  = wr_pm ? wr_data_i[1:0]
                             : (pm_en_reg & {2{~(wr_ctrl
                                 & wr_data_i[special_input_pkg::CTRL_CNT_EN_LSB])}}); // [R16]

  // Configuration registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      mode_reg     <= special_input_pkg::DECODE_MODE_RST;
      cnt_en_reg   <= special_input_pkg::CNT_EN_RST;
      pm_en_reg    <= special_input_pkg::PM_EN_RST;
      edge_en_reg  <= special_input_pkg::EDGE_EN_RST;
      edge_pol_reg <= special_input_pkg::EDGE_POL_RST;
    end
    else
    begin
      if (wr_ctrl)
        mode_reg <= wr_data_i[special_input_pkg::CTRL_MODE_LSB +: 2]; // [R10]
      cnt_en_reg <= cnt_en_next;
      pm_en_reg  <= pm_en_next;
      if (wr_een)
        edge_en_reg <= wr_data_i[4:0]; // [R11]
      if (wr_epol)
        edge_pol_reg <= wr_data_i[4:0]; // [R12]
    end
  end

  // Microsecond tick and frequency gate window
  localparam logic [6:0] US_LAST = 7'(special_input_pkg::US_CYCLES - 1);
  logic [6:0]  us_div_reg;
  logic        us_tick_reg;
  logic [31:0] gate_cnt_reg;
  logic        gate_end_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      us_div_reg   <= 7'h00;
      us_tick_reg  <= 1'b0;
      gate_cnt_reg <= 32'h0;
      gate_end_reg <= 1'b0;
    end
    else
    begin
      us_tick_reg  <= (us_div_reg == US_LAST);
      us_div_reg   <= (us_div_reg == US_LAST) ? 7'h00 : us_div_reg + 7'h01;
      gate_end_reg <= (gate_cnt_reg == 32'(GATE_CYCLES - 1));
      gate_cnt_reg <= (gate_cnt_reg == 32'(GATE_CYCLES - 1)) ? 32'h0 : gate_cnt_reg + 32'h1;
    end
  end

  // Counter and pulse meter channels
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic [1:0]       ab;
    logic [1:0]       sub_reg;
    logic [1:0]       ab_prev_reg;
    logic             enhanced;
    logic             simple_up;
    logic             simple_dn;
    logic             enh_up;
    logic             enh_dn;
    logic             cnt_up;
    logic             cnt_dn;
    logic [CNT_W-1:0] count_next;
    special_input_pkg::quad_step_t step;
    logic [MEAS_W-1:0] hi_us_reg;
    logic [MEAS_W-1:0] edges_reg;

    assign ab        = {filt_reg[2*c], filt_reg[2*c+1]}; // [R1] [R6]
    assign enhanced  = mode_reg[c]; // [R10]
    assign step      = quad_step(ab_prev_reg, ab);
    // Simple decode counts edges only, so one phase alone still counts
    assign simple_up = rise[2*c] & ~filt_reg[2*c+1]; // [R2] [R4]
    assign simple_dn = rise[2*c+1] & ~filt_reg[2*c]; // [R3] [R5]
    // Enhanced decode: jitter back and forth cancels within one cycle
    assign enh_up    = (step == special_input_pkg::STEP_UP) && (sub_reg == 2'h3); // [R9]
    assign enh_dn    = (step == special_input_pkg::STEP_DOWN) && (sub_reg == 2'h0); // [R9]
    assign cnt_up    = cnt_en_reg[c] & (enhanced ? enh_up : simple_up);
    assign cnt_dn    = cnt_en_reg[c] & (enhanced ? enh_dn : simple_dn);
    assign count_next = cnt_up ? count_reg[c] + 1'b1
                      : cnt_dn ? count_reg[c] - 1'b1 : count_reg[c];
    assign match_hit[c] = (cnt_up | cnt_dn) && (count_next == target_reg[c]); // [R7]

    // Position counter, phase tracker and reloadable target
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
      begin
        count_reg[c]  <= '0;
        target_reg[c] <= '0;
        sub_reg       <= 2'h0;
        ab_prev_reg   <= 2'h0;
      end
      else
      begin
        ab_prev_reg <= ab;
        if (step == special_input_pkg::STEP_UP)
          sub_reg <= sub_reg + 2'h1;
        else if (step == special_input_pkg::STEP_DOWN)
          sub_reg <= sub_reg - 2'h1;
        count_reg[c] <= wr_count[c] ? wr_data_i[CNT_W-1:0] : count_next;
        if (wr_target[c])
          target_reg[c] <= wr_data_i[CNT_W-1:0]; // [R7]
      end
    end

    // High time in us and edges per one second window
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
      begin
        hi_us_reg    <= '0;
        edges_reg    <= '0;
        width_reg[c] <= '0;
        freq_reg[c]  <= '0;
      end
      else if (!pm_en_reg[c])
      begin
        hi_us_reg <= '0;
        edges_reg <= '0;
      end
      else
      begin
        if (rise[c])
          hi_us_reg <= '0;
        else if (filt_reg[c] && us_tick_reg && !(&hi_us_reg))
          hi_us_reg <= hi_us_reg + 1'b1; // Saturates on very slow inputs
        if (fall[c])
          width_reg[c] <= hi_us_reg; // [R14]
        if (gate_end_reg)
        begin
          freq_reg[c] <= edges_reg; // [R14]
          edges_reg   <= {{(MEAS_W-1){1'b0}}, rise[c]};
        end
        else if (rise[c])
          edges_reg <= edges_reg + 1'b1;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      match_sts_reg <= 2'h0;
      edge_sts_reg  <= 5'h00;
      match_req_reg <= 2'h0;
      edge_req_reg  <= 5'h00;
    end
    else
    begin
      match_req_reg <= match_hit; // [R7]
      edge_req_reg  <= edge_hit; // [R13]
      match_sts_reg <= match_hit | (match_sts_reg
                     & ~({2{wr_status}} & wr_data_i[special_input_pkg::STAT_MATCH_LSB +: 2]));
      edge_sts_reg  <= edge_hit
                     | (edge_sts_reg
                     & ~({5{wr_status}} & wr_data_i[special_input_pkg::STAT_EDGE_LSB +: 5]));
    end
  end

  // Read selection; unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0;
    case (addr_i)
      special_input_pkg::CTRL_OFS:     rd_mux = {28'h0, cnt_en_reg, mode_reg};
      special_input_pkg::PM_EN_OFS:    rd_mux = {30'h0, pm_en_reg};
      special_input_pkg::EDGE_EN_OFS:  rd_mux = {27'h0, edge_en_reg};
      special_input_pkg::EDGE_POL_OFS: rd_mux = {27'h0, edge_pol_reg};
      special_input_pkg::STATUS_OFS:   rd_mux = {25'h0, edge_sts_reg, match_sts_reg};
      special_input_pkg::TARGET0_OFS:  rd_mux = 32'(target_reg[0]);
      special_input_pkg::TARGET1_OFS:  rd_mux = 32'(target_reg[1]);
      special_input_pkg::COUNT0_OFS:   rd_mux = 32'(count_reg[0]);
      special_input_pkg::COUNT1_OFS:   rd_mux = 32'(count_reg[1]);
      special_input_pkg::WIDTH0_OFS:   rd_mux = 32'(width_reg[0]);
      special_input_pkg::WIDTH1_OFS:   rd_mux = 32'(width_reg[1]);
      special_input_pkg::FREQ0_OFS:    rd_mux = 32'(freq_reg[0]);
      special_input_pkg::FREQ1_OFS:    rd_mux = 32'(freq_reg[1]);
      special_input_pkg::PINS_OFS:     rd_mux = {27'h0, filt_reg};
      default:                         rd_mux = 32'h0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      rd_data_reg <= 32'h0;
    else
      rd_data_reg <= rd_i ? rd_mux : 32'h0;
  end

  assign rd_data_o   = rd_data_reg;
  assign match_req_o = match_req_reg;
  assign edge_req_o  = edge_req_reg;

endmodule : special_input_counters

`default_nettype wire

// >>> tb/special_input_counters_monitor.sv
// Purpose: Port checker for the special input counters
// Assumes: Sees the top-level ports only
// Notes:   Quiet count flags requests with no pin activity behind them
`timescale 1ns/10ps
`default_nettype none
module special_input_counters_monitor (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  pin_i,
  input wire logic [7:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [1:0]  match_req_o,
  input wire logic [4:0]  edge_req_o
);
  logic [4:0] quiet_reg;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // Cycles since any pin moved, saturating
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || pin_i != $past(pin_i))
      quiet_reg <= 5'h00;
    else if (quiet_reg != 5'h1f)
      quiet_reg <= quiet_reg + 5'h01;
  end
  rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data not zero outside read slot");
  unmapped_rd_a: assert property (rd_i && addr_i == 8'hfc |=> rd_data_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> rd_data_o == 32'h0 && match_req_o == 2'h0 && edge_req_o == 5'h00)
    else $error("outputs active after reset");
  match_pulse_a: assert property (match_req_o != 2'h0 |=>
    (match_req_o & $past(match_req_o)) == 2'h0) else $error("match longer than a cycle");
  edge_pulse_a: assert property (edge_req_o != 5'h00 |=>
    (edge_req_o & $past(edge_req_o)) == 5'h00) else $error("edge longer than a cycle");
  sync_delay_a: assert property ($changed(pin_i) |=>
    (edge_req_o == 5'h00 && match_req_o == 2'h0) [*2]) else $error("request skips sync");
  quiet_pins_a: assert property (quiet_reg > 5'h0c |->
    edge_req_o == 5'h00 && match_req_o == 2'h0) else $error("request without pin edge");
  ctrl_width_a: assert property (rd_i && addr_i == special_input_pkg::CTRL_OFS
    |=> rd_data_o[31:4] == 28'h0) else $error("control upper bits set");
  pins_width_a: assert property (rd_i && addr_i == special_input_pkg::PINS_OFS
    |=> rd_data_o[31:5] == 27'h0) else $error("pin levels upper bits set");
endmodule : special_input_counters_monitor
bind special_input_counters special_input_counters_monitor i_special_input_counters_monitor (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .pin_i(pin_i), .addr_i(addr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .match_req_o(match_req_o), .edge_req_o(edge_req_o));
`default_nettype wire

// >>> tb/pulse_source_model.sv
// Purpose: Encoder and pulse source on the five special pins
// Assumes: Changes just after rising edges of the bench clock
// Notes:   Step gaps are core cycles, far faster than a real encoder
`timescale 1ns/10ps
`default_nettype none
module pulse_source_model (
  input  wire logic       clk_i,
  output logic      [4:0] pins_o
);
  initial pins_o = 5'h00;
  // Idle for n cycles
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold
  // Drive all pins at once
  task automatic set(input logic [4:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask : set
  // Whole gray cycles, {B,A}; up lets phase A lead
  task automatic quad(input int ch, input bit up, input int n, input int gap);
    logic [1:0] seq [4];
    if (up)
      seq = '{2'b01, 2'b11, 2'b10, 2'b00};
    else
      seq = '{2'b10, 2'b11, 2'b01, 2'b00};
    for (int i = 0; i < n * 4; i++)
    begin
      @(posedge clk_i);
      pins_o[2*ch +: 2] <= seq[i % 4];
      hold(gap);
    end
  endtask : quad
  // Single-phase pulses on one pin
  task automatic pulse(input int b, input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      pins_o[b] <= 1'b1;
      hold(hi);
      pins_o[b] <= 1'b0;
      hold(lo);
    end
  endtask : pulse
endmodule : pulse_source_model
`default_nettype wire

// >>> tb/special_input_counters_tb.sv
// Purpose: Register-level tests of the special input counters
// Assumes: Pins come from the pulse source model
// Notes:   Short frequency gate keeps the run brief
`timescale 1ns/10ps
`default_nettype none
module special_input_counters_tb;
  localparam int GATE = 1000;
  logic        clk;
  logic        rst = 1'b1;
  logic [4:0]  pins;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  match_req;
  logic [4:0]  edge_req;
  logic [4:0]  edge_par = 5'h00;
  logic [4:0]  base;
  logic [7:0]  n_match = 8'h00;
  logic [31:0] got;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  special_input_counters #(.GATE_CYCLES(GATE)) i_special_input_counters (
    .core_clk_i(clk), .rst_i(rst), .pin_i(pins), .addr_i(addr), .wr_data_i(wdata),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .match_req_o(match_req), .edge_req_o(edge_req));
  pulse_source_model i_pulse_source_model (.clk_i(clk), .pins_o(pins));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tally request pulses; parity per pin survives without a clear
  always @(posedge clk)
  begin
    edge_par <= edge_par ^ edge_req;
    n_match <= n_match + {7'h00, match_req[0]} + {7'h00, match_req[1]};
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      $display("[FAIL] %0t timeout", $time);
      n_fail++;
      results();
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    if (g !== e)
      n_fail++;
  endtask : chk
  // Measured results carry a tick of slack
  task automatic chk_in(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    total_checks++;
    if ((g >= lo && g <= hi) !== 1'b1)
      $display("[FAIL] %0t got %h outside %h..%h", $time, g, lo, hi);
    if ((g >= lo && g <= hi) !== 1'b1)
      n_fail++;
  endtask : chk_in
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, got);
    chk(got, e);
  endtask : chk_rd
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_rd(special_input_pkg::CTRL_OFS, 32'h0);
    chk_rd(special_input_pkg::EDGE_POL_OFS, 32'h1f);
    chk_rd(8'hfc, 32'h0);
    $display("reset done");
    wr_reg(special_input_pkg::CTRL_OFS, 32'h4);
    i_pulse_source_model.quad(0, 1'b1, 3, 20);
    chk_rd(special_input_pkg::COUNT0_OFS, 32'h3);
    i_pulse_source_model.quad(0, 1'b0, 2, 20);
    chk_rd(special_input_pkg::COUNT0_OFS, 32'h1);
    i_pulse_source_model.pulse(0, 2, 20, 20);
    chk_rd(special_input_pkg::COUNT0_OFS, 32'h3);
    i_pulse_source_model.pulse(1, 3, 20, 20);
    chk_rd(special_input_pkg::COUNT0_OFS, 32'h0);
    wr_reg(special_input_pkg::CTRL_OFS, 32'hc);
    i_pulse_source_model.quad(1, 1'b1, 2, 20);
    i_pulse_source_model.pulse(3, 1, 20, 20);
    chk_rd(special_input_pkg::COUNT1_OFS, 32'h1);
    chk_rd(special_input_pkg::COUNT0_OFS, 32'h0);
    $display("simple decode done");
    wr_reg(special_input_pkg::TARGET0_OFS, 32'h2);
    i_pulse_source_model.quad(0, 1'b1, 2, 20);
    wr_reg(special_input_pkg::TARGET0_OFS, 32'h4);
    i_pulse_source_model.quad(0, 1'b1, 2, 20);
    chk({24'h0, n_match}, 32'h3);
    chk_rd(special_input_pkg::STATUS_OFS, 32'h1);
    wr_reg(special_input_pkg::TARGET1_OFS, 32'h1);
    chk_rd(special_input_pkg::TARGET1_OFS, 32'h1);
    $display("target done");
    // Jitter on phase A counts in simple mode, nets zero when enhanced
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(special_input_pkg::CTRL_OFS, {28'h0, 2'h3, m[1:0]});
      wr_reg(special_input_pkg::COUNT0_OFS, 32'h0);
      wr_reg(special_input_pkg::COUNT1_OFS, 32'h0);
      i_pulse_source_model.pulse(0, 2, 20, 20);
      i_pulse_source_model.pulse(2, 2, 20, 20);
      i_pulse_source_model.quad(0, 1'b1, 1, 20);
      i_pulse_source_model.quad(1, 1'b1, 1, 20);
      chk_rd(special_input_pkg::COUNT0_OFS, m[0] ? 32'h1 : 32'h3);
      chk_rd(special_input_pkg::COUNT1_OFS, m[1] ? 32'h1 : 32'h3);
    end
    chk({24'h0, n_match}, 32'h7);
    $display("decode modes done");
    wr_reg(special_input_pkg::CTRL_OFS, 32'h0);
    wr_reg(special_input_pkg::STATUS_OFS, 32'h7f);
    wr_reg(special_input_pkg::EDGE_EN_OFS, 32'h1f);
    wr_reg(special_input_pkg::EDGE_POL_OFS, 32'h15);
    base = edge_par;
    i_pulse_source_model.set(5'h1f);
    i_pulse_source_model.hold(12);
    chk({27'h0, edge_par ^ base}, 32'h15);
    wr_reg(special_input_pkg::PINS_OFS, 32'hff);
    chk_rd(special_input_pkg::PINS_OFS, 32'h1f);
    i_pulse_source_model.set(5'h00);
    i_pulse_source_model.hold(12);
    chk({27'h0, edge_par ^ base}, 32'h1f);
    chk_rd(special_input_pkg::STATUS_OFS, 32'h7c);
    wr_reg(special_input_pkg::EDGE_EN_OFS, 32'h0);
    base = edge_par;
    i_pulse_source_model.pulse(4, 1, 20, 20);
    chk({27'h0, edge_par ^ base}, 32'h0);
    $display("edge events done");
    wr_reg(special_input_pkg::CTRL_OFS, 32'h4);
    wr_reg(special_input_pkg::PM_EN_OFS, 32'h3);
    chk_rd(special_input_pkg::CTRL_OFS, 32'h0);
    i_pulse_source_model.pulse(0, 6, 300, 200);
    chk_rd(special_input_pkg::COUNT0_OFS, 32'h1);
    rd_reg(special_input_pkg::WIDTH0_OFS, got);
    chk_in(got, 32'h2, 32'h4);
    rd_reg(special_input_pkg::FREQ0_OFS, got);
    chk_in(got, 32'h1, 32'h3);
    i_pulse_source_model.pulse(1, 3, 300, 200);
    rd_reg(special_input_pkg::WIDTH1_OFS, got);
    chk_in(got, 32'h2, 32'h4);
    rd_reg(special_input_pkg::FREQ1_OFS, got);
    chk_in(got, 32'h1, 32'h3);
    wr_reg(special_input_pkg::CTRL_OFS, 32'h4);
    chk_rd(special_input_pkg::PM_EN_OFS, 32'h0);
    $display("pulse measure done");
    results();
  end
endmodule : special_input_counters_tb
`default_nettype wire
